// *** rtl/serial_adc_readout_consts.svh ***
// Constants for the serial converter readout block
`ifndef SERIAL_ADC_READOUT_CONSTS_SVH
`define SERIAL_ADC_READOUT_CONSTS_SVH

// ----------------------------------------
// Resolution and frame layout
// ----------------------------------------
`define RES_BITS      12     // Resolution variant: 12, 10 or 8
`define CNT_W         5      // Width of the falling-edge counter
`define LEAD_ZEROS    5'h04  // Zero bits ahead of the result
`define RES_LAST_CNT  5'h0f  // Edge count of the result LSB (4 + RES_BITS - 1)
`define FRAME_BITS    5'h10  // Bits in one serial word

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SEL_RST       1'h1   // Deselected after reset
`define SCLK_RST      1'h0   // Serial clock sampled low after reset

`endif

// *** rtl/serial_adc_pkg.sv ***
// Types shared by the serial converter readout modules
`include "serial_adc_readout_consts.svh"
package serial_adc_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [`RES_BITS-1:0] code_t;
  typedef logic [`CNT_W-1:0]    edge_cnt_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FRAME = 3'b010,
    ST_DONE  = 3'b100
  } frame_state_t;

endpackage

// *** rtl/sar_if.sv ***
// Carrier between frame control and the approximation engine
`timescale 1ns/1ns
interface sar_if;
  import serial_adc_pkg::*;

  logic  start;   // Capture sample, begin conversion
  logic  abort;   // Drop conversion, back to track
  logic  step;    // One approximation step
  code_t sample;  // Input code to capture
  logic  cmp;     // Decision of the current trial bit
  logic  last;    // Current trial is the LSB
  logic  busy;    // Conversion in progress (hold mode)

  modport engine (input start, abort, step, sample, output cmp, last, busy);
  modport ctrl   (output start, abort, step, sample, input cmp, last, busy);
endinterface

// *** rtl/sar_engine.sv ***
// Successive-approximation engine stepped by serial clock edges
`timescale 1ns/1ns
module sar_engine
  import serial_adc_pkg::*;
(
  input wire logic core_clk_i,  // Core clock
  input wire logic rst_b_i,     // Synchronous reset, active low
  sar_if.engine    cv           // Control from the frame logic
);

  code_t held_r;
  code_t held_nxt;
  code_t result_r;
  code_t result_nxt;
  code_t mask_r;
  code_t mask_nxt;
  logic  busy_r;
  logic  busy_nxt;

  // ----------------------------------------
  // Trial decision
  // ----------------------------------------
  // Straight binary: keep the trial bit when the held input reaches it
  assign cv.cmp  = (held_r >= (result_r | mask_r));
  assign cv.last = mask_r[0];
  assign cv.busy = busy_r;

  // Next conversion state
  always_comb begin
    held_nxt   = held_r;
    result_nxt = result_r;
    mask_nxt   = mask_r;
    busy_nxt   = busy_r;
    if (cv.start) begin
      held_nxt   = cv.sample;                        // Hold the input
      result_nxt = '0;
      mask_nxt   = {1'b1, {(`RES_BITS-1){1'b0}}};
      busy_nxt   = 1'b1;
    end else if (cv.abort) begin
      busy_nxt   = 1'b0;
    end else if (cv.step && busy_r) begin
      if (cv.cmp) begin
        result_nxt = result_r | mask_r;
      end
      mask_nxt = mask_r >> 1;
      if (mask_r[0]) begin
        busy_nxt = 1'b0;                             // Back to track
      end
    end
  end

  // Conversion registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      held_r   <= '0;
      result_r <= '0;
      mask_r   <= '0;
      busy_r   <= 1'b0;
    end else begin
      held_r   <= held_nxt;
      result_r <= result_nxt;
      mask_r   <= mask_nxt;
      busy_r   <= busy_nxt;
    end
  end

endmodule

// *** rtl/serial_adc_readout.sv ***
// Serial conversion control and result readout of the converter
`timescale 1ns/1ns
module serial_adc_readout
  import serial_adc_pkg::*;
(
  input  wire logic   core_clk_i,           // Core clock, 10 MHz
  input  wire logic   rst_b_i,              // Synchronous reset, active low
  input  wire logic   sclk_i,               // Serial clock from the host
  input  wire logic   sel_b_i,              // Select, active low
  input  wire code_t  vin_code_i,           // Digitised analog input level
  output logic        serial_result_out_o,  // Serial data, output value
  output logic        serial_result_oe_o,   // Serial data, output enable
  output logic        track_o               // Sampling stage in track mode
);

  sar_if cv ();

  logic         sclk_s1_r;
  logic         sclk_s2_r;
  logic         sclk_prev_r;
  logic         sel_s1_r;
  logic         sel_s2_r;
  code_t        vin_s1_r;
  code_t        vin_s2_r;
  logic         sclk_fall;
  frame_state_t state_r;
  frame_state_t state_nxt;
  edge_cnt_t    cnt_r;
  edge_cnt_t    cnt_nxt;
  logic         out_r;
  logic         out_nxt;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Two flops on every pin; edge detect compares the second with a third serial clock flop
  // Code input is a multi-bit pin: hold it steady around select
  // Each serial clock phase must span at least three core cycles
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      sclk_s1_r   <= `SCLK_RST;
      sclk_s2_r   <= `SCLK_RST;
      sclk_prev_r <= `SCLK_RST;
      sel_s1_r    <= `SEL_RST;
      sel_s2_r    <= `SEL_RST;
      vin_s1_r    <= '0;
      vin_s2_r    <= '0;
    end else begin
      sclk_s1_r   <= sclk_i;
      sclk_s2_r   <= sclk_s1_r;
      sclk_prev_r <= sclk_s2_r;
      sel_s1_r    <= sel_b_i;
      sel_s2_r    <= sel_s1_r;
      vin_s1_r    <= vin_code_i;
      vin_s2_r    <= vin_s1_r;
    end
  end

  assign sclk_fall = sclk_prev_r & ~sclk_s2_r;

  // ----------------------------------------
  // Frame control
  // ----------------------------------------
  // Frame timeline in serial clock falls:
  //   select low: conversion starts, first leading zero out
  //   falls 1 to 3: remaining leading zeros
  //   falls 4 to result LSB: one decision each, shifted out at once
  //   falls after the LSB: pad zeros for shorter variants
  //   fall 16: word complete, line released
  // Select high at any point drops the conversion and the line
  // Next frame state, edge count, serial bit and engine commands
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    out_nxt   = out_r;
    cv.start  = 1'b0;
    cv.abort  = 1'b0;
    cv.step   = 1'b0;
    cv.sample = vin_s2_r;
    case (state_r)
      ST_IDLE: begin
        if (!sel_s2_r) begin                        // Select low
          state_nxt = ST_FRAME;
          cnt_nxt   = '0;
          out_nxt   = 1'b0;                         // First leading zero
          cv.start  = 1'b1;
        end
      end
      ST_FRAME: begin
        if (sel_s2_r) begin                         // Released early
          state_nxt = ST_IDLE;
          cv.abort  = 1'b1;
        end else if (sclk_fall) begin
          cnt_nxt = cnt_r + 5'h01;
          out_nxt = 1'b0;                           // Lead and pad zeros
          if ((cnt_nxt >= `LEAD_ZEROS) && (cnt_nxt <= `RES_LAST_CNT)) begin
            cv.step = 1'b1;
            out_nxt = cv.cmp;                       // Result bit, MSB first
          end
          if (cnt_nxt == `FRAME_BITS) begin
            state_nxt = ST_DONE;                    // Word complete
          end
        end
      end
      ST_DONE: begin
        if (sel_s2_r) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cv.abort  = 1'b1;
      end
    endcase
  end

  // Frame registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      out_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      out_r   <= out_nxt;
    end
  end

  // ----------------------------------------
  // Approximation engine
  // ----------------------------------------
  // Stepped by the same falls that shift the word out
  sar_engine u_engine (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .cv         (cv)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign serial_result_out_o = out_r;
  assign serial_result_oe_o  = (state_r == ST_FRAME);
  assign track_o             = ~cv.busy;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  // Serial clock and conversion steps
  step_on_fall_a: assert property (
    cv.step |-> sclk_fall && !sel_s2_r)
    else $error("conversion stepped without a serial clock fall");
  busy_hold_a: assert property (
    cv.busy && !sclk_fall && !sel_s2_r |=> cv.busy)
    else $error("conversion ended without a serial clock fall");
  bit_on_fall_a: assert property (
    (state_r == ST_FRAME) && $stable(state_r) && $changed(out_r) |-> $past(sclk_fall))
    else $error("serial bit changed without a serial clock fall");
  fall_count_a: assert property (
    (state_r == ST_FRAME) && $stable(state_r) && !$past(sclk_fall) |-> $stable(cnt_r))
    else $error("edge count moved without a serial clock fall");

  // Word layout
  first_zero_a: assert property (
    (state_r == ST_IDLE) && !sel_s2_r |=> !serial_result_out_o && (cnt_r == 5'h00))
    else $error("frame did not open on a leading zero");
  lead_zero_a: assert property (
    serial_result_oe_o && (cnt_r < `LEAD_ZEROS) |-> !out_r)
    else $error("leading bit not zero");
  step_window_a: assert property (
    cv.step |=> (cnt_r >= `LEAD_ZEROS) && (cnt_r <= `RES_LAST_CNT))
    else $error("decision outside the result bits");
  last_bit_a: assert property (
    cv.step && cv.last |=> cnt_r == `RES_LAST_CNT)
    else $error("last decision not at the result LSB");
  pad_zero_a: assert property (
    serial_result_oe_o && (cnt_r > `RES_LAST_CNT) |-> !out_r)
    else $error("trailing pad bit not zero");
  word_length_a: assert property (
    serial_result_oe_o && sclk_fall && !sel_s2_r && (cnt_r == 5'h0f)
    |=> !serial_result_oe_o && (state_r == ST_DONE))
    else $error("frame not ended after sixteen bits");
  frame_bound_a: assert property (
    (state_r == ST_FRAME) |-> (cnt_r < `FRAME_BITS))
    else $error("frame ran past sixteen bits");
  binary_bit_a: assert property (
    cv.step |=> out_r == $past(cv.cmp))
    else $error("serial bit differs from the trial decision");

  // Start, track and abort
  select_start_a: assert property (
    (state_r == ST_IDLE) && !sel_s2_r |=> cv.busy && serial_result_oe_o && !track_o)
    else $error("select did not start a conversion");
  one_conv_a: assert property (
    (state_r == ST_DONE) && !sel_s2_r |=> (state_r == ST_DONE) && track_o)
    else $error("second conversion inside one select period");
  back_to_track_a: assert property (
    cv.step && cv.last && cv.busy |=> track_o ##1 track_o || !sel_s2_r)
    else $error("not in track after the last decision");
  track_in_frame_a: assert property (
    (state_r == ST_FRAME) |-> (track_o == (cnt_r >= `RES_LAST_CNT)))
    else $error("track mode out of step with the conversion");
  abort_track_a: assert property (
    cv.abort |=> track_o && !serial_result_oe_o)
    else $error("released select left a conversion running");

  // Output enable
  hiz_deselect_a: assert property (
    sel_s2_r |=> !serial_result_oe_o)
    else $error("output driven while deselected");

  // Main scenarios
  full_frame_c: cover property ((state_r == ST_FRAME) ##1 (state_r == ST_DONE));
  early_abort_c: cover property (cv.busy && sel_s2_r ##1 track_o);
  one_bit_c: cover property (cv.step && cv.cmp);
  zero_bit_c: cover property (cv.step && !cv.cmp);
  restart_c: cover property ((state_r == ST_DONE) ##1 (state_r == ST_IDLE));

endmodule

// *** tb/host_port_model.sv ***
// Host serial port model: drives select and serial clock, captures the word
`timescale 1ns/1ns
module host_port_model (
  input  wire logic core_clk_i,  // Bench core clock
  input  wire logic data_i,      // Serial data value
  input  wire logic oe_i,        // Serial data enable
  input  wire logic track_i,     // Sampling stage tracking
  output logic      sclk_o,      // Serial clock to device
  output logic      sel_b_o      // Select, active low
);
  logic last_r;  // Last driven level of the data line
  logic line;    // Level the host sees on the line

  initial begin
    sclk_o  = 1'h0;
    sel_b_o = 1'h1;
    last_r  = 1'h0;
  end

  // Released line reads the inverse of its last driven level
  assign line = oe_i ? data_i : ~last_r;
  always @(posedge core_clk_i) begin
    if (oe_i) last_r <= data_i;
  end

  // Select low, then falls of an 800 ns serial clock; clock idles low
  task automatic frame(input int n, output logic [15:0] w, output logic [15:0] en,
                       output logic [15:0] trk);
    w   = '0;
    en  = '0;
    trk = '0;
    @(negedge core_clk_i) sel_b_o = 1'h0;
    repeat (8) @(negedge core_clk_i);
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'h1;
      repeat (4) @(negedge core_clk_i);
      w[15-i]   = line;  // Capture just before the fall
      en[15-i]  = oe_i;
      trk[15-i] = track_i;
      sclk_o = 1'h0;
      repeat (4) @(negedge core_clk_i);
    end
  endtask

  // One serial clock period with select left high
  task automatic idle_clock();
    sclk_o = 1'h1;
    repeat (4) @(negedge core_clk_i);
    sclk_o = 1'h0;
    repeat (4) @(negedge core_clk_i);
  endtask

  // Deselect and let the device see it
  task automatic release_sel();
    sel_b_o = 1'h1;
    repeat (4) @(negedge core_clk_i);
  endtask
endmodule

// *** tb/serial_adc_readout_bench.sv ***
// Self-checking bench of the serial converter readout block
`timescale 1ns/1ns
`include "serial_adc_readout_consts.svh"
module serial_adc_readout_bench;
  import serial_adc_pkg::*;
  logic        core_clk_i, rst_b_i, sclk, sel_b, dout, doe, track;
  code_t       vin;
  int          miscompares, n_tests;
  logic [15:0] w, en, trk;

  serial_adc_readout dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk),
    .sel_b_i(sel_b), .vin_code_i(vin), .serial_result_out_o(dout),
    .serial_result_oe_o(doe), .track_o(track));
  host_port_model host (.core_clk_i(core_clk_i), .data_i(dout), .oe_i(doe),
    .track_i(track), .sclk_o(sclk), .sel_b_o(sel_b));

  // Clock generation
  initial core_clk_i = 1'h0;
  always #50 core_clk_i = ~core_clk_i;

  // Compare seen against expected
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Full conversion and readout of one code
  task automatic t_word(input code_t c);
    @(negedge core_clk_i) vin = c;
    repeat (4) @(negedge core_clk_i);
    host.frame(16, w, en, trk);
    check(w, 16'(c) << (12 - `RES_BITS));
    check(en, 16'hffff);
    check(trk, 16'h0001);
    repeat (2) @(negedge core_clk_i);
    check({15'h0, doe}, 16'h0000);
    host.release_sel();
    check({15'h0, track}, 16'h0001);
    $display("word test %h done", c);
  endtask

  // Select released mid-frame, then serial clock while deselected
  task automatic t_abort();
    host.frame(5, w, en, trk);
    check(en, 16'hf800);
    check(w, {4'h0, vin[`RES_BITS-1], 11'h0});
    host.release_sel();
    check({14'h0, doe, track}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      host.idle_clock();
      check({15'h0, doe}, 16'h0000);
    end
    $display("abort test done");
  endtask

  // Watchdog for a hung run
  initial begin
    #2000000;
    miscompares++;
    stop_test();
  end

  // Main sequence
  initial begin
    miscompares = 0;
    n_tests = 0;
    rst_b_i = 1'h0;
    vin = '0;
    repeat (5) @(negedge core_clk_i);
    rst_b_i = 1'h1;
    repeat (3) @(negedge core_clk_i);
    check({14'h0, doe, track}, 16'h0001);
    t_word('0);
    t_word('1);
    t_word(code_t'(12'ha5c));
    t_abort();
    t_word(code_t'(12'h5a3));
    t_word(code_t'(12'h801));
    stop_test();
  end
endmodule
